// ==== logic/dac_frontend_pkg.sv ====
// Package: constants, register map and types of the converter's serial front end
package dac_frontend_pkg;
	localparam int FRAME_BITS    = 32;
	localparam int PAYLOAD_BITS  = 24;
	localparam logic [5:0] LEN_FULL  = 6'h20;
	localparam logic [5:0] LEN_SHORT = 6'h18;
	localparam logic [7:0] CRC_POLY  = 8'h07;
	localparam logic [1:0] RB_SYNC   = 2'h2;

	localparam logic [4:0] A_IDLE      = 5'h00;
	localparam logic [4:0] A_INPUT     = 5'h01;
	localparam logic [4:0] A_APPLIED   = 5'h02;
	localparam logic [4:0] A_GAIN      = 5'h03;
	localparam logic [4:0] A_OFFSET    = 5'h04;
	localparam logic [4:0] A_CLEAR     = 5'h05;
	localparam logic [4:0] A_KEY       = 5'h06;
	localparam logic [4:0] A_WDT_CFG   = 5'h07;
	localparam logic [4:0] A_DIAG      = 5'h08;
	localparam logic [4:0] A_FAULT_CFG = 5'h09;
	localparam logic [4:0] A_IF_CFG    = 5'h0A;
	localparam logic [4:0] A_RB_SEL    = 5'h0B;
	localparam logic [4:0] A_STATUS    = 5'h0C;

	localparam logic [15:0] GAIN_RST      = 16'hFFFF;
	localparam logic [15:0] OFFSET_RST    = 16'h8000;
	localparam logic [15:0] WDT_CFG_RST   = 16'h0000;
	localparam logic [15:0] FAULT_CFG_RST = 16'h0003;
	localparam logic [15:0] IF_CFG_RST    = 16'h0001;
	localparam logic [5:0]  DIAG_RST      = 6'h10;
	localparam logic [18:0] OFFSET_ZERO   = 19'h08000;

	localparam int WDT_EN = 0;
	localparam int WDT_KICK_ANY = 1;
	localparam int WDT_RESET_ACT = 9;
	localparam int WDT_CLEAR_ACT = 10;
	localparam int D_CRC = 0;
	localparam int D_SLIP = 1;
	localparam int D_COUNT = 2;
	localparam int D_WDT = 3;
	localparam int D_RESET = 4;
	localparam int D_OVER = 5;
	localparam int F_CRC = 0;
	localparam int F_WDT = 1;
	localparam int IF_CRC_EN = 0;
	localparam int IF_STATUS_RB = 1;
	localparam int IF_ECHO = 2;

	localparam logic [15:0] KICK_KEY_DEF = 16'h5A5A;
	localparam logic [15:0] LOAD_KEY     = 16'h1234;
	localparam logic [15:0] RESET_KEY_1  = 16'h15FA;
	localparam logic [15:0] RESET_KEY_2  = 16'hAF51;

	localparam int CLOCK_HZ = 25_000_000;
	localparam int WDT_TIMEOUT_MS = 1000;
	localparam int WDT_TIMEOUT_CYCLES_DEF = (CLOCK_HZ / 1000) * WDT_TIMEOUT_MS;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		FR_IDLE  = 2'b00,
		FR_SHIFT = 2'b01,
		FR_CHECK = 2'b11
	} frame_state_e;

	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] data;
	} command_s;
endpackage

// ==== logic/dac_frontend.sv ====
// Serial frame checking, readback, watchdog and trim for the converter front end
// What this block does
// [R1] Accept frames only matching address pins
// [R2] Verify frames with x^8+x^2+x+1 check
// [R3] Host sends 32 bits with check enabled
// [R4] Bad check: drop, fault low, flags set
// [R5] Diag bit 0 write-one clears check error
// [R6] Fault config decides check error pin effect
// [R7] Slip bit must invert next bit
// [R8] Exactly 32 (or 24) falling edges accepted
// [R9] Select register, next idle frame reads back
// [R10] Readback layout: 10, fault, addr, data, check
// [R11] Status mode outputs status, blocks two-stage
// [R12] Echo mode alternates status and last command
// [R13] Watchdog restarts on selected kick frame
// [R14] Expiry: clear code, software reset per bits
// [R15] Expiry always sets watchdog status and flag
// [R16] After expiry ignore input writes, loads
// [R17] Watchdog reset defaults: off, 1 s, key
// [R18] Gain trim straight binary, reset FFFF
// [R19] Offset trim straight binary, reset 8000
// [R20] Code = D*(M+1)/65536 + C - 32768
// [R21] Trim writes apply at next input write
// [R22] Applied-code register returns untrimmed input
// [R23] Sample input MSB first, falling serial edge
// [R24] Write frame: slip, addr, reg, data, check
// [R25] Load strobe low: update at select rise
// [R26] Write-one reloads sticky flag with fault state
`timescale 1ns/1ps
`default_nettype none

module frame_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = wr_ptr_reg == rd_ptr_reg;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clock) begin
		if (in_valid && !full) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // frame_fifo

module dac_frontend #(
	parameter int          WDT_TIMEOUT_CYCLES = dac_frontend_pkg::WDT_TIMEOUT_CYCLES_DEF,
	parameter logic [15:0] KICK_KEY           = dac_frontend_pkg::KICK_KEY_DEF
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        sclk,
	input  wire logic        sync_n,
	input  wire logic        sdin,
	input  wire logic        load_strobe_n,
	input  wire logic        device_address_pin_0,
	input  wire logic        device_address_pin_1,
	output logic             sdo,
	output logic             fault_n,
	output logic      [15:0] dac_code
);
	// Pin order: sclk, sync_n, sdin, load_strobe_n, address 1, address 0
	logic [5:0]  pin_s1_reg;
	logic [5:0]  pin_s2_reg;
	logic [1:0]  edge_reg;
	logic        sclk_fall;
	logic        sync_fall;
	logic        sync_rise;
	dac_frontend_pkg::frame_state_e state_reg;
	logic [31:0] rx_reg;
	logic [31:0] tx_reg;
	logic [31:0] tx_word;
	logic [5:0]  cnt_reg;
	logic        sdo_reg;
	logic [31:0] word;
	logic        crc_en;
	logic        len_ok;
	logic        slip_ok;
	logic        crc_ok;
	logic        addr_ok;
	logic        accept;
	logic        checking;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        drain_busy_reg;
	logic        wr;
	dac_frontend_pkg::command_s fifo_out;
	dac_frontend_pkg::command_s last_cmd_reg;
	logic [15:0] gain_reg;
	logic [15:0] offset_reg;
	logic [15:0] clear_reg;
	logic [15:0] wdt_cfg_reg;
	logic [15:0] fault_cfg_reg;
	logic [15:0] if_cfg_reg;
	logic [4:0]  rb_addr_reg;
	logic        rb_pending_reg;
	logic        echo_phase_reg;
	logic [5:0]  diag_reg;
	logic [5:0]  diag_next;
	logic [5:0]  diag_event;
	logic        fault_n_reg;
	logic        key_stage_reg;
	logic        soft_rst_reg;
	logic        kick;
	logic        sw_load;
	logic        expire;
	logic        wdt_run_reg;
	logic [31:0] wdt_cnt_reg;
	logic [15:0] input_reg;
	logic [15:0] applied_reg;
	logic [15:0] trimmed_reg;
	logic [15:0] trimmed;
	logic        load_pending_reg;
	logic [15:0] dac_reg;
	logic [15:0] status_word;
	logic [15:0] rd_data;

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		logic       fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? dac_frontend_pkg::CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [31:0] pack(input logic f, input logic [4:0] a, input logic [15:0] d);
		logic [23:0] body;
		body = {dac_frontend_pkg::RB_SYNC, f, a, d};
		return {body, crc8(body)};
	endfunction

	// Only the second stage and the edge register are read by logic
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// Idle pin levels (clock low, select and strobe high), so no false edge follows reset
			pin_s1_reg <= 6'h14;
			pin_s2_reg <= 6'h14;
			edge_reg <= 2'h1;
		end else begin
			pin_s1_reg <= {sclk, sync_n, sdin, load_strobe_n, device_address_pin_1, device_address_pin_0};
			pin_s2_reg <= pin_s1_reg;
			edge_reg <= pin_s2_reg[5:4];
		end
	end
	assign sclk_fall = edge_reg[1] && !pin_s2_reg[5];
	assign sync_fall = edge_reg[0] && !pin_s2_reg[4];
	assign sync_rise = !edge_reg[0] && pin_s2_reg[4];

	// [R23] MSB first, falling edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= dac_frontend_pkg::FR_IDLE;
			rx_reg <= 32'h0;
			tx_reg <= 32'h0;
			cnt_reg <= 6'h00;
			sdo_reg <= 1'b0;
		end else begin
			case (state_reg)
				dac_frontend_pkg::FR_IDLE: begin
					if (sync_fall) begin
						state_reg <= dac_frontend_pkg::FR_SHIFT;
						cnt_reg <= 6'h00;
						tx_reg <= tx_word;
						sdo_reg <= tx_word[31];
					end
				end
				dac_frontend_pkg::FR_SHIFT: begin
					if (sync_rise) begin
						state_reg <= dac_frontend_pkg::FR_CHECK;
					end else if (sclk_fall) begin
						rx_reg <= {rx_reg[30:0], pin_s2_reg[3]};
						cnt_reg <= (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
						tx_reg <= {tx_reg[30:0], 1'b0};
						sdo_reg <= tx_reg[30];
					end
				end
				dac_frontend_pkg::FR_CHECK: begin
					state_reg <= dac_frontend_pkg::FR_IDLE;
				end
				default: begin
					state_reg <= dac_frontend_pkg::FR_IDLE;
				end
			endcase
		end
	end

	// [R24] Short frames sit low in the register
	assign word = (cnt_reg == dac_frontend_pkg::LEN_FULL) ? rx_reg : {rx_reg[23:0], 8'h00};
	assign crc_en = if_cfg_reg[dac_frontend_pkg::IF_CRC_EN];
	assign checking = state_reg == dac_frontend_pkg::FR_CHECK;
	// [R8] Edge count check
	assign len_ok = crc_en ? (cnt_reg == dac_frontend_pkg::LEN_FULL)
		: (cnt_reg == dac_frontend_pkg::LEN_FULL || cnt_reg == dac_frontend_pkg::LEN_SHORT);
	// [R7] Slip bit test
	assign slip_ok = word[31] != word[30];
	// [R2] Frame check compare
	assign crc_ok = !crc_en || (crc8(word[31:8]) == word[7:0]);
	// [R1] Address pin match
	assign addr_ok = word[30:29] == pin_s2_reg[1:0];
	assign accept = checking && len_ok && slip_ok && crc_ok && addr_ok;
	assign diag_event = {accept && !fifo_in_ready, soft_rst_reg, expire,
		checking && !len_ok, checking && len_ok && !slip_ok,
		checking && len_ok && slip_ok && !crc_ok};

	frame_fifo #(
		.WIDTH ($bits(dac_frontend_pkg::command_s)),
		.DEPTH (dac_frontend_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (accept),
		.in_ready  (fifo_in_ready),
		.in_data   (word[28:8]),
		.out_valid (fifo_out_valid),
		.out_ready (!drain_busy_reg),
		.out_data  (fifo_out)
	);

	// The apply stage takes every other cycle, so the queue can back up
	assign wr = fifo_out_valid && !drain_busy_reg;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			drain_busy_reg <= 1'b0;
			last_cmd_reg <= '0;
		end else begin
			drain_busy_reg <= wr;
			if (wr) begin
				last_cmd_reg <= fifo_out;
			end
		end
	end

	// [R18] [R19] [R17] Configuration with reset values
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gain_reg <= dac_frontend_pkg::GAIN_RST;
			offset_reg <= dac_frontend_pkg::OFFSET_RST;
			clear_reg <= 16'h0000;
			wdt_cfg_reg <= dac_frontend_pkg::WDT_CFG_RST;
			fault_cfg_reg <= dac_frontend_pkg::FAULT_CFG_RST;
			if_cfg_reg <= dac_frontend_pkg::IF_CFG_RST;
		end else if (soft_rst_reg) begin
			gain_reg <= dac_frontend_pkg::GAIN_RST;
			offset_reg <= dac_frontend_pkg::OFFSET_RST;
			clear_reg <= 16'h0000;
			wdt_cfg_reg <= dac_frontend_pkg::WDT_CFG_RST;
			fault_cfg_reg <= dac_frontend_pkg::FAULT_CFG_RST;
			if_cfg_reg <= dac_frontend_pkg::IF_CFG_RST;
		end else if (wr) begin
			case (fifo_out.addr)
				dac_frontend_pkg::A_GAIN: gain_reg <= fifo_out.data;
				dac_frontend_pkg::A_OFFSET: offset_reg <= fifo_out.data;
				dac_frontend_pkg::A_CLEAR: clear_reg <= fifo_out.data;
				dac_frontend_pkg::A_WDT_CFG: wdt_cfg_reg <= fifo_out.data;
				dac_frontend_pkg::A_FAULT_CFG: fault_cfg_reg <= fifo_out.data;
				dac_frontend_pkg::A_IF_CFG: if_cfg_reg <= fifo_out.data;
				default: begin
				end
			endcase
		end
	end

	// [R5] [R26] Write-one reloads with this cycle's event; a new event wins
	always_comb begin
		diag_next = diag_reg | diag_event;
		if (wr && fifo_out.addr == dac_frontend_pkg::A_DIAG) begin
			diag_next = (diag_reg & ~fifo_out.data[5:0]) | diag_event;
		end
	end
	// [R4] [R15] Sticky flags
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			diag_reg <= dac_frontend_pkg::DIAG_RST;
		end else begin
			diag_reg <= diag_next;
		end
	end

	// [R6] [R4] Fault pin from configured flags
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fault_n_reg <= 1'b1;
		end else begin
			fault_n_reg <= !((diag_reg[dac_frontend_pkg::D_CRC] && fault_cfg_reg[dac_frontend_pkg::F_CRC])
				|| (diag_reg[dac_frontend_pkg::D_WDT] && fault_cfg_reg[dac_frontend_pkg::F_WDT]));
		end
	end

	// [R13] Kick frame selection
	assign kick = wr && (wdt_cfg_reg[dac_frontend_pkg::WDT_KICK_ANY]
		|| (fifo_out.addr == dac_frontend_pkg::A_KEY && fifo_out.data == KICK_KEY));
	assign sw_load = wr && fifo_out.addr == dac_frontend_pkg::A_KEY
		&& fifo_out.data == dac_frontend_pkg::LOAD_KEY;
	assign expire = wdt_run_reg && wdt_cnt_reg == 32'(WDT_TIMEOUT_CYCLES - 1);

	// Two consecutive key writes, or an expiry with the reset action, reset the settings
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			key_stage_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= 1'b0;
			if (wr && fifo_out.addr == dac_frontend_pkg::A_KEY) begin
				key_stage_reg <= fifo_out.data == dac_frontend_pkg::RESET_KEY_1;
				soft_rst_reg <= key_stage_reg && fifo_out.data == dac_frontend_pkg::RESET_KEY_2;
			end else if (wr) begin
				key_stage_reg <= 1'b0;
			end
			// [R14] Reset action
			if (expire && wdt_cfg_reg[dac_frontend_pkg::WDT_RESET_ACT]) begin
				soft_rst_reg <= 1'b1;
			end
		end
	end

	// [R16] Kick restarts only once the flag is clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wdt_run_reg <= 1'b0;
			wdt_cnt_reg <= 32'h0;
		end else if (!wdt_cfg_reg[dac_frontend_pkg::WDT_EN] || soft_rst_reg) begin
			wdt_run_reg <= 1'b0;
			wdt_cnt_reg <= 32'h0;
		end else if (expire) begin
			wdt_run_reg <= 1'b0;
			wdt_cnt_reg <= 32'h0;
		end else if (kick && !diag_reg[dac_frontend_pkg::D_WDT]) begin
			wdt_run_reg <= 1'b1;
			wdt_cnt_reg <= 32'h0;
		end else if (wdt_run_reg) begin
			wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
		end
	end

	// [R20] Trim, clamped to the code range
	always_comb begin
		logic [32:0] prod;
		logic [18:0] sum;
		prod = {17'h0, fifo_out.data} * {16'h0, gain_reg + 17'h1};
		sum = {2'b00, prod[32:16]} + {3'b000, offset_reg};
		if (sum < dac_frontend_pkg::OFFSET_ZERO) begin
			trimmed = 16'h0000;
		end else if (sum - dac_frontend_pkg::OFFSET_ZERO > 19'h0FFFF) begin
			trimmed = 16'hFFFF;
		end else begin
			trimmed = 16'(sum - dac_frontend_pkg::OFFSET_ZERO);
		end
	end

	// [R21] Trims are taken only at an input write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			input_reg <= 16'h0000;
			applied_reg <= 16'h0000;
			trimmed_reg <= 16'h0000;
			load_pending_reg <= 1'b0;
			dac_reg <= 16'h0000;
		end else if (expire && wdt_cfg_reg[dac_frontend_pkg::WDT_CLEAR_ACT]) begin
			// [R14] Clear code; a fresh input write is needed afterwards
			dac_reg <= clear_reg;
			applied_reg <= clear_reg;
			load_pending_reg <= 1'b0;
		end else if (!diag_reg[dac_frontend_pkg::D_WDT]) begin
			// [R25] Strobe low updates at once
			if (wr && fifo_out.addr == dac_frontend_pkg::A_INPUT) begin
				input_reg <= fifo_out.data;
				trimmed_reg <= trimmed;
				load_pending_reg <= pin_s2_reg[2];
				if (!pin_s2_reg[2]) begin
					dac_reg <= trimmed;
					applied_reg <= fifo_out.data;
				end
			end else if (load_pending_reg && (!pin_s2_reg[2] || sw_load)) begin
				dac_reg <= trimmed_reg;
				// [R22] Untrimmed code for readback
				applied_reg <= input_reg;
				load_pending_reg <= 1'b0;
			end
		end
	end

	// [R15] Summary bits
	assign status_word = {13'h0, !fault_n_reg, diag_reg[dac_frontend_pkg::D_WDT], |diag_reg};

	always_comb begin
		case (rb_addr_reg)
			dac_frontend_pkg::A_INPUT: rd_data = input_reg;
			dac_frontend_pkg::A_APPLIED: rd_data = applied_reg;
			dac_frontend_pkg::A_GAIN: rd_data = gain_reg;
			dac_frontend_pkg::A_OFFSET: rd_data = offset_reg;
			dac_frontend_pkg::A_CLEAR: rd_data = clear_reg;
			dac_frontend_pkg::A_WDT_CFG: rd_data = wdt_cfg_reg;
			dac_frontend_pkg::A_DIAG: rd_data = {10'h0, diag_reg};
			dac_frontend_pkg::A_FAULT_CFG: rd_data = fault_cfg_reg;
			dac_frontend_pkg::A_IF_CFG: rd_data = if_cfg_reg;
			dac_frontend_pkg::A_RB_SEL: rd_data = {11'h0, rb_addr_reg};
			dac_frontend_pkg::A_STATUS: rd_data = status_word;
			default: rd_data = 16'h0000;
		endcase
	end

	// [R10] [R11] [R12] Readback word chosen at frame start
	always_comb begin
		tx_word = 32'h0;
		if (if_cfg_reg[dac_frontend_pkg::IF_STATUS_RB] || if_cfg_reg[dac_frontend_pkg::IF_ECHO]) begin
			if (if_cfg_reg[dac_frontend_pkg::IF_ECHO] && echo_phase_reg) begin
				tx_word = pack(!fault_n_reg, last_cmd_reg.addr, last_cmd_reg.data);
			end else begin
				tx_word = pack(!fault_n_reg, dac_frontend_pkg::A_STATUS, status_word);
			end
		end else if (rb_pending_reg) begin
			tx_word = pack(!fault_n_reg, rb_addr_reg, rd_data);
		end
	end

	// [R9] Select write arms the next frame
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rb_addr_reg <= 5'h00;
			rb_pending_reg <= 1'b0;
			echo_phase_reg <= 1'b0;
		end else begin
			if (sync_fall && state_reg == dac_frontend_pkg::FR_IDLE) begin
				rb_pending_reg <= 1'b0;
				echo_phase_reg <= !echo_phase_reg && if_cfg_reg[dac_frontend_pkg::IF_ECHO];
			end
			if (wr && fifo_out.addr == dac_frontend_pkg::A_RB_SEL) begin
				rb_addr_reg <= fifo_out.data[4:0];
				rb_pending_reg <= 1'b1;
			end
		end
	end

	assign sdo = sdo_reg;
	assign fault_n = fault_n_reg;
	assign dac_code = dac_reg;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_addr_gate;
		checking && !addr_ok |=> $stable(u_fifo.wr_ptr_reg);
	endproperty
	a_addr_gate: assert property (p_addr_gate) else $error("frame with wrong address accepted"); // [R1]

	property p_crc_flag;
		checking && len_ok && slip_ok && !crc_ok |=> diag_reg[0]
			##1 (fault_cfg_reg[0] ? !fault_n : (fault_n || diag_reg[3]));
	endproperty
	a_crc_flag: assert property (p_crc_flag) else $error("check error not flagged"); // [R4]

	property p_slip_flag;
		checking && len_ok && !slip_ok |-> !accept ##1 diag_reg[1];
	endproperty
	a_slip_flag: assert property (p_slip_flag) else $error("slip error not flagged"); // [R7]

	property p_count_flag;
		checking && cnt_reg != 6'h20 && cnt_reg != 6'h18 |-> !accept ##1 diag_reg[2];
	endproperty
	a_count_flag: assert property (p_count_flag) else $error("edge count error not flagged"); // [R8]

	property p_sync_bits;
		sync_fall && state_reg == dac_frontend_pkg::FR_IDLE && tx_word != 32'h0
			|=> tx_reg[31:30] == 2'b10 && tx_reg[7:0] == crc8(tx_reg[31:8]);
	endproperty
	a_sync_bits: assert property (p_sync_bits) else $error("readback word malformed"); // [R10]

	property p_wdt_flag;
		expire |=> diag_reg[3] && status_word[1] && !wdt_run_reg;
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog expiry not flagged"); // [R15]

	property p_wdt_block;
		diag_reg[3] && !expire |=> $stable(input_reg) && $stable(dac_reg);
	endproperty
	a_wdt_block: assert property (p_wdt_block) else $error("input accepted after expiry"); // [R16]

	property p_trim_quiet;
		wr && (fifo_out.addr == 5'h03 || fifo_out.addr == 5'h04) && !expire && !load_pending_reg
			|=> $stable(dac_reg);
	endproperty
	a_trim_quiet: assert property (p_trim_quiet) else $error("trim write moved output"); // [R21]

	property p_soft_defaults;
		soft_rst_reg |=> gain_reg == 16'hFFFF && offset_reg == 16'h8000 && wdt_cfg_reg == 16'h0000;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("reset values wrong"); // [R18]

	c_good_write: cover property (accept ##[1:40] wr);
	c_crc_bad: cover property (checking && len_ok && slip_ok && !crc_ok);
	c_expire: cover property (expire);
	c_fifo_full: cover property (!fifo_in_ready);
endmodule // dac_frontend

`default_nettype wire

// ==== dv/spi_host.sv ====
// Host serial master model that drives frames and collects readback
`timescale 1ns/1ps
`default_nettype none
module spi_host (
	input  wire logic clock,
	output logic      sclk,
	output logic      sync_n,
	output logic      sdin,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		sdin = 1'b0;
	end
	task automatic xfer(input logic [31:0] f, input int n, output logic [31:0] rx);
		rx = 32'h0;
		@(negedge clock) sync_n = 1'b0;
		repeat (4) @(negedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			sdin = f[i];
			sclk = 1'b1;
			rx = {rx[30:0], sdo};
			repeat (4) @(negedge clock);
			sclk = 1'b0;
			repeat (4) @(negedge clock);
		end
		sync_n = 1'b1;
		// Deselected line must not look like held data
		sdin = ~sdin;
		repeat (12) @(negedge clock);
	endtask
endmodule // spi_host
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the converter front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic             clock = 1'b0;
	logic             resetn = 1'b0;
	logic             load_strobe_n = 1'b0;
	logic       [1:0] pins;
	wire logic        sclk, sync_n, sdin, sdo, fault_n;
	wire logic [15:0] dac_code;
	logic      [31:0] lfsr = 32'h2892;
	logic      [31:0] rx;
	logic      [15:0] gm = 16'hFFFF, om = 16'h8000, dm = 16'h0000, ed = 16'h0000, clr;
	logic             wd = 1'b0;
	int               n_fail = 0;
	int               cmp_count = 0;
	always #20 clock = ~clock;
	spi_host i_spi_host (.clock(clock), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));
	dac_frontend #(.WDT_TIMEOUT_CYCLES(800)) i_dac_frontend (.clock(clock), .resetn(resetn),
		.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .load_strobe_n(load_strobe_n),
		.device_address_pin_0(pins[0]), .device_address_pin_1(pins[1]), .sdo(sdo),
		.fault_n(fault_n), .dac_code(dac_code));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] crc8(input logic [23:0] p);
		logic [7:0] c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? dac_frontend_pkg::CRC_POLY : 8'h00);
		return c;
	endfunction
	function automatic logic [31:0] frm(input logic s, input logic [1:0] a,
		input logic [4:0] r, input logic [15:0] d);
		logic [23:0] p = {s ^ ~a[1], a, r, d};
		return {p, crc8(p)};
	endfunction
	function automatic logic [15:0] trim(input logic [15:0] d);
		longint t = ((longint'(d) * (longint'(gm) + 1)) >> 16) + longint'(om) - 32768;
		return (t < 0) ? 16'h0000 : (t > 65535) ? 16'hFFFF : t[15:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] d);
		i_spi_host.xfer(frm(1'b0, pins, r, d), 32, rx);
		if (r == dac_frontend_pkg::A_GAIN) gm = d;
		if (r == dac_frontend_pkg::A_OFFSET) om = d;
		if (r == dac_frontend_pkg::A_INPUT && !wd) begin
			dm = d;
			ed = trim(d);
		end
	endtask
	task automatic bad(input logic s, input logic [1:0] a, input int n, input logic [31:0] x);
		i_spi_host.xfer(frm(s, a, dac_frontend_pkg::A_INPUT, 16'h00FF) ^ x, n, rx);
	endtask
	task automatic rb(input logic [4:0] a, input logic [15:0] d, input logic f);
		wr(dac_frontend_pkg::A_RB_SEL, {11'h000, a});
		wr(dac_frontend_pkg::A_IDLE, 16'h0000);
		chk(rx, {2'h2, f, a, d, crc8({2'h2, f, a, d})});
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		pins = lfsr[1:0];
		repeat (20) @(negedge clock);
		resetn = 1'b1;
		chk(32'(dac_code), 0);
		chk(32'(fault_n), 1);
		repeat (3) @(negedge clock);
		rb(dac_frontend_pkg::A_GAIN, 16'hFFFF, 1'b0);
		rb(dac_frontend_pkg::A_OFFSET, 16'h8000, 1'b0);
		rb(dac_frontend_pkg::A_WDT_CFG, 16'h0000, 1'b0);
		lfsr = nxt(lfsr);
		clr = lfsr[15:0];
		wr(dac_frontend_pkg::A_CLEAR, clr);
		wr(dac_frontend_pkg::A_WDT_CFG, 16'h0401);
		wr(dac_frontend_pkg::A_KEY, dac_frontend_pkg::KICK_KEY_DEF);
		repeat (400) @(negedge clock);
		wr(dac_frontend_pkg::A_KEY, dac_frontend_pkg::KICK_KEY_DEF);
		repeat (600) @(negedge clock);
		chk(32'(fault_n), 1);
		repeat (250) @(negedge clock);
		chk(32'(dac_code), 32'(clr));
		chk(32'(fault_n), 0);
		wd = 1'b1;
		ed = clr;
		wr(dac_frontend_pkg::A_INPUT, 16'h0F0F);
		chk(32'(dac_code), 32'(clr));
		rb(dac_frontend_pkg::A_DIAG, 16'h0018, 1'b1);
		wr(dac_frontend_pkg::A_DIAG, 16'h003F);
		wd = 1'b0;
		bad(1'b0, pins, 32, 32'h1);
		chk(32'(dac_code), 32'(clr));
		chk(32'(fault_n), 0);
		rb(dac_frontend_pkg::A_DIAG, 16'h0001, 1'b1);
		wr(dac_frontend_pkg::A_DIAG, 16'h0001);
		chk(32'(fault_n), 1);
		wr(dac_frontend_pkg::A_FAULT_CFG, 16'h0002);
		bad(1'b0, pins, 32, 32'h1);
		chk(32'(fault_n), 1);
		wr(dac_frontend_pkg::A_DIAG, 16'h0001);
		bad(1'b0, ~pins, 32, 32'h0);
		bad(1'b1, pins, 32, 32'h0);
		bad(1'b0, pins, 31, 32'h0);
		chk(32'(dac_code), 32'(clr));
		rb(dac_frontend_pkg::A_DIAG, 16'h0006, 1'b0);
		wr(dac_frontend_pkg::A_DIAG, 16'h003F);
		wr(dac_frontend_pkg::A_FAULT_CFG, 16'h0003);
		for (int k = 0; k < 3; k++) begin
			lfsr = nxt(lfsr);
			wr(dac_frontend_pkg::A_GAIN, lfsr[31:16]);
			wr(dac_frontend_pkg::A_OFFSET, lfsr[15:0]);
			chk(32'(dac_code), 32'(ed));
			lfsr = nxt(lfsr);
			wr(dac_frontend_pkg::A_INPUT, lfsr[15:0]);
			chk(32'(dac_code), 32'(ed));
			rb(dac_frontend_pkg::A_APPLIED, dm, 1'b0);
		end
		load_strobe_n = 1'b1;
		clr = ed;
		lfsr = nxt(lfsr);
		wr(dac_frontend_pkg::A_INPUT, lfsr[15:0]);
		chk(32'(dac_code), 32'(clr));
		load_strobe_n = 1'b0;
		repeat (8) @(negedge clock);
		chk(32'(dac_code), 32'(ed));
		wr(dac_frontend_pkg::A_IF_CFG, 16'h0003);
		wr(dac_frontend_pkg::A_RB_SEL, {11'h000, dac_frontend_pkg::A_GAIN});
		wr(dac_frontend_pkg::A_IDLE, 16'h0000);
		chk(32'(rx[31:24]), 32'({2'h2, 1'b0, dac_frontend_pkg::A_STATUS}));
		wr(dac_frontend_pkg::A_IF_CFG, 16'h0005);
		lfsr = nxt(lfsr);
		wr(dac_frontend_pkg::A_CLEAR, lfsr[15:0]);
		chk(32'(rx[31:8]), 32'({2'h2, 1'b0, dac_frontend_pkg::A_STATUS, 16'h0000}));
		wr(dac_frontend_pkg::A_IDLE, 16'h0000);
		chk(rx, {2'h2, 1'b0, dac_frontend_pkg::A_CLEAR, lfsr[15:0],
			crc8({2'h2, 1'b0, dac_frontend_pkg::A_CLEAR, lfsr[15:0]})});
		wr(dac_frontend_pkg::A_KEY, dac_frontend_pkg::RESET_KEY_1);
		wr(dac_frontend_pkg::A_KEY, dac_frontend_pkg::RESET_KEY_2);
		rb(dac_frontend_pkg::A_GAIN, 16'hFFFF, 1'b0);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
